// file: design/agpp_pkg.sv
package agpp_pkg;

  localparam int PORT_W = 8;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;

  // register indices; the byte address is four times the index
  localparam logic [15:0] IDX_LOW_PCR = 16'hffac;
  localparam logic [15:0] IDX_HIGH_PCR = 16'hffad;
  localparam logic [15:0] IDX_LOW_DDR = 16'hffb0;
  localparam logic [15:0] IDX_HIGH_DDR = 16'hffb1;
  localparam logic [15:0] IDX_LOW_DR = 16'hffb2;
  localparam logic [15:0] IDX_HIGH_DR = 16'hffb3;

  localparam logic [ADDR_W-1:0] ADDR_LOW_PCR = {IDX_LOW_PCR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_HIGH_PCR = {IDX_HIGH_PCR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LOW_DDR = {IDX_LOW_DDR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_HIGH_DDR = {IDX_HIGH_DDR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LOW_DR = {IDX_LOW_DR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_HIGH_DR = {IDX_HIGH_DR, 2'b00};

  localparam logic [PORT_W-1:0] DDR_RST = 8'h00;
  localparam logic [PORT_W-1:0] DDR_ALL_OUT = 8'hff;
  localparam logic [PORT_W-1:0] DDR_READ_VAL = 8'hff;
  localparam logic [PORT_W-1:0] DR_RST = 8'h00;
  localparam logic [PORT_W-1:0] PCR_RST = 8'h00;
  localparam logic [PORT_W-1:0] BITS_OFF = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
  localparam logic [1:0] MODE_SYNC_RST = 2'h3;
  localparam logic HW_SYNC_RST = 1'b0;
  localparam logic HW_STBY_RST = 1'b1;

  typedef enum logic [1:0] {
    AGPP_MODE_1 = 2'b01,
    AGPP_MODE_2 = 2'b10,
    AGPP_MODE_3 = 2'b11
  } agpp_mode_e;

  localparam agpp_mode_e MODE_RST = AGPP_MODE_3;

endpackage : agpp_pkg

// file: design/agpp_port.sv
`timescale 1ns/1ps
module agpp_port (
  input wire logic clk,
  input wire logic rst_n,
  input agpp_pkg::agpp_mode_e mode,
  input wire logic hw_stby,
  input wire logic wr_ddr,
  input wire logic wr_dr,
  input wire logic wr_pcr,
  input wire logic [agpp_pkg::PORT_W-1:0] wdata,
  input wire logic [agpp_pkg::PORT_W-1:0] addr_bits,
  input wire logic [agpp_pkg::PORT_W-1:0] pin_in,
  output logic [agpp_pkg::PORT_W-1:0] ddr_q,
  output logic [agpp_pkg::PORT_W-1:0] dr_q,
  output logic [agpp_pkg::PORT_W-1:0] pcr_q,
  output logic [agpp_pkg::PORT_W-1:0] dr_view,
  output logic [agpp_pkg::PORT_W-1:0] pin_out,
  output logic [agpp_pkg::PORT_W-1:0] pin_oe,
  output logic [agpp_pkg::PORT_W-1:0] pullup_en
);
  import agpp_pkg::*;

  typedef struct packed {
    logic [PORT_W-1:0] ddr;
    logic [PORT_W-1:0] dr;
    logic [PORT_W-1:0] pcr;
    logic [PORT_W-1:0] sync1;
    logic [PORT_W-1:0] sync2;
    logic [PORT_W-1:0] sync3;
    logic [PORT_W-1:0] level;
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
    logic [PORT_W-1:0] pu;
  } agpp_port_s;

  localparam agpp_port_s PORT_RST = '{DDR_RST, DR_RST, PCR_RST, BITS_OFF, BITS_OFF,
    BITS_OFF, BITS_OFF, BITS_OFF, BITS_OFF, BITS_OFF};

  agpp_port_s st_reg;
  agpp_port_s st_next;
  logic [PORT_W-1:0] ddr_eff;
  logic [PORT_W-1:0] settled;

  always_comb begin
    st_next = st_reg;
    ddr_eff = (mode == AGPP_MODE_1) ? DDR_ALL_OUT : st_reg.ddr;
    // a pin bit is taken only once the second and third stages agree
    settled = ~(st_reg.sync2 ^ st_reg.sync3);
    st_next.sync1 = pin_in;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    st_next.level = (st_reg.sync2 & settled) | (st_reg.level & ~settled);
    if (hw_stby) begin
      st_next.ddr = (mode == AGPP_MODE_1) ? DDR_ALL_OUT : DDR_RST;
      st_next.dr = DR_RST;
      st_next.pcr = PCR_RST;
    end else begin
      // nothing but reset and hardware standby clears state: sleep keeps it
      if (mode == AGPP_MODE_1) begin
        st_next.ddr = DDR_ALL_OUT;
      end else if (wr_ddr) begin
        st_next.ddr = wdata;
      end
      if (wr_dr) begin
        st_next.dr = wdata;
      end
      if (wr_pcr) begin
        st_next.pcr = wdata;
      end
    end
    unique case (mode)
      AGPP_MODE_1: begin
        st_next.out = addr_bits;
        st_next.oe = DDR_ALL_OUT;
        st_next.pu = BITS_OFF;
      end
      AGPP_MODE_2: begin
        st_next.out = addr_bits;
        st_next.oe = ddr_eff;
        st_next.pu = st_reg.pcr & ~ddr_eff;
      end
      AGPP_MODE_3: begin
        st_next.out = st_reg.dr;
        st_next.oe = ddr_eff;
        st_next.pu = st_reg.pcr & ~ddr_eff;
      end
    endcase
    if (hw_stby) begin
      st_next.oe = BITS_OFF;
      st_next.pu = BITS_OFF;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= PORT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dr_view = (st_reg.dr & ddr_eff) | (st_reg.level & ~ddr_eff);
  assign ddr_q = st_reg.ddr;
  assign dr_q = st_reg.dr;
  assign pcr_q = st_reg.pcr;
  assign pin_out = st_reg.out;
  assign pin_oe = st_reg.oe;
  assign pullup_en = st_reg.pu;

endmodule : agpp_port

// file: design/agpp_top.sv
// Behaviour
// - mode 1: direction all ones, unwritable
// - mode 1: pins drive address low/high bytes
// - hardware standby floats address outputs
// - mode 2: direction one outputs address bit
// - mode 2 reset leaves all pins inputs
// - mode 3: direction one drives latch bit
// - modes 2 and 3: direction reads ones
// - reset, hardware standby clear direction (mode 1 ones)
// - software standby keeps direction and outputs
// - data read: latch if output, else pin
// - latch cleared by reset/standby, kept sleeping
// - pull-up on when control one, direction zero
// - mode 1: pull-ups always off
// - pull-up control cleared by reset, hardware standby
// - each pin has its own pull-up bit
`timescale 1ns/1ps
module agpp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [agpp_pkg::ADDR_W-1:0] paddr,
  input wire logic [agpp_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [agpp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] mode_pins,
  input wire logic hw_standby_n,
  input wire logic [15:0] ext_addr,
  input wire logic [agpp_pkg::PORT_W-1:0] low_pin_in,
  output logic [agpp_pkg::PORT_W-1:0] low_pin_out,
  output logic [agpp_pkg::PORT_W-1:0] low_pin_oe,
  output logic [agpp_pkg::PORT_W-1:0] low_pullup_en,
  input wire logic [agpp_pkg::PORT_W-1:0] high_pin_in,
  output logic [agpp_pkg::PORT_W-1:0] high_pin_out,
  output logic [agpp_pkg::PORT_W-1:0] high_pin_oe,
  output logic [agpp_pkg::PORT_W-1:0] high_pullup_en
);
  import agpp_pkg::*;

  typedef struct packed {
    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    logic [1:0] mode_s3;
    agpp_mode_e mode;
    logic hw_s1;
    logic hw_s2;
    logic hw_s3;
    logic hw;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } agpp_top_s;

  localparam agpp_top_s TOP_RST = '{MODE_SYNC_RST, MODE_SYNC_RST, MODE_SYNC_RST, MODE_RST,
    HW_SYNC_RST, HW_SYNC_RST, HW_SYNC_RST, HW_STBY_RST, RDATA_RST, 1'b0, 1'b0};

  agpp_top_s st_reg;
  agpp_top_s st_next;

  logic hit_lpcr;
  logic hit_hpcr;
  logic hit_lddr;
  logic hit_hddr;
  logic hit_ldr;
  logic hit_hdr;
  logic mapped;
  logic wr_fire;
  logic [PORT_W-1:0] rd_byte;
  logic [PORT_W-1:0] low_ddr;
  logic [PORT_W-1:0] low_dr;
  logic [PORT_W-1:0] low_pcr;
  logic [PORT_W-1:0] low_view;
  logic [PORT_W-1:0] high_ddr;
  logic [PORT_W-1:0] high_dr;
  logic [PORT_W-1:0] high_pcr;
  logic [PORT_W-1:0] high_view;

  always_comb begin
    hit_lpcr = (paddr == ADDR_LOW_PCR);
    hit_hpcr = (paddr == ADDR_HIGH_PCR);
    hit_lddr = (paddr == ADDR_LOW_DDR);
    hit_hddr = (paddr == ADDR_HIGH_DDR);
    hit_ldr = (paddr == ADDR_LOW_DR);
    hit_hdr = (paddr == ADDR_HIGH_DR);
    mapped = hit_lpcr | hit_hpcr | hit_lddr | hit_hddr | hit_ldr | hit_hdr;
    // a write lands only on the completing edge; lane 0 carries the byte
    wr_fire = psel & penable & st_reg.pready & pwrite & ~st_reg.pslverr & pstrb[0];
    rd_byte = BITS_OFF;
    if (hit_lpcr) begin
      rd_byte = low_pcr;
    end else if (hit_hpcr) begin
      rd_byte = high_pcr;
    end else if (hit_lddr | hit_hddr) begin
      rd_byte = DDR_READ_VAL;
    end else if (hit_ldr) begin
      rd_byte = low_view;
    end else if (hit_hdr) begin
      rd_byte = high_view;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.mode_s1 = mode_pins;
    st_next.mode_s2 = st_reg.mode_s1;
    st_next.mode_s3 = st_reg.mode_s2;
    // mode straps are only taken once two late stages agree, so a glitch cannot flip the map
    if (st_reg.mode_s2 == st_reg.mode_s3) begin
      unique case (st_reg.mode_s2)
        2'b01: st_next.mode = AGPP_MODE_1;
        2'b10: st_next.mode = AGPP_MODE_2;
        default: st_next.mode = AGPP_MODE_3;
      endcase
    end
    st_next.hw_s1 = hw_standby_n;
    st_next.hw_s2 = st_reg.hw_s1;
    st_next.hw_s3 = st_reg.hw_s2;
    if (st_reg.hw_s2 == st_reg.hw_s3) begin
      st_next.hw = ~st_reg.hw_s2;
    end
    // one wait state buys a registered read path
    if (psel && penable && !st_reg.pready) begin
      st_next.pready = 1'b1;
      st_next.pslverr = ~mapped;
      st_next.prdata = (pwrite || !mapped) ? RDATA_RST : {24'h00_0000, rd_byte};
    end else begin
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= TOP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;

  agpp_port u_low (
    .clk(pclk),
    .rst_n(presetn),
    .mode(st_reg.mode),
    .hw_stby(st_reg.hw),
    .wr_ddr(wr_fire & hit_lddr),
    .wr_dr(wr_fire & hit_ldr),
    .wr_pcr(wr_fire & hit_lpcr),
    .wdata(pwdata[PORT_W-1:0]),
    .addr_bits(ext_addr[7:0]),
    .pin_in(low_pin_in),
    .ddr_q(low_ddr),
    .dr_q(low_dr),
    .pcr_q(low_pcr),
    .dr_view(low_view),
    .pin_out(low_pin_out),
    .pin_oe(low_pin_oe),
    .pullup_en(low_pullup_en)
  );

  agpp_port u_high (
    .clk(pclk),
    .rst_n(presetn),
    .mode(st_reg.mode),
    .hw_stby(st_reg.hw),
    .wr_ddr(wr_fire & hit_hddr),
    .wr_dr(wr_fire & hit_hdr),
    .wr_pcr(wr_fire & hit_hpcr),
    .wdata(pwdata[PORT_W-1:0]),
    .addr_bits(ext_addr[15:8]),
    .pin_in(high_pin_in),
    .ddr_q(high_ddr),
    .dr_q(high_dr),
    .pcr_q(high_pcr),
    .dr_view(high_view),
    .pin_out(high_pin_out),
    .pin_oe(high_pin_oe),
    .pullup_en(high_pullup_en)
  );

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic awake;
  logic is_m1;
  logic is_m2;
  logic is_m3;
  assign awake = ~st_reg.hw;
  assign is_m1 = (st_reg.mode == AGPP_MODE_1);
  assign is_m2 = (st_reg.mode == AGPP_MODE_2);
  assign is_m3 = (st_reg.mode == AGPP_MODE_3);

  sequence s_access(logic [ADDR_W-1:0] a, logic w);
    psel && !penable && paddr == a && pwrite == w ##1
    psel && penable && !pready && paddr == a && pwrite == w;
  endsequence

  sequence s_steady_mode(logic m);
    (m && awake) [*2];
  endsequence

  chk_m1_ddr_ones: assert property (
    s_steady_mode(is_m1) |-> low_ddr == DDR_ALL_OUT && high_ddr == DDR_ALL_OUT)
    else $error("direction not held at all ones in mode 1");

  chk_m1_addr_drive: assert property (
    s_steady_mode(is_m1) ##1 is_m1 && awake |->
      low_pin_oe == DDR_ALL_OUT && high_pin_oe == DDR_ALL_OUT &&
      low_pin_out == $past(ext_addr[7:0]) && high_pin_out == $past(ext_addr[15:8]))
    else $error("mode 1 pins do not carry the bus address");

  chk_hw_float: assert property (
    st_reg.hw |=> low_pin_oe == BITS_OFF && high_pin_oe == BITS_OFF &&
      low_pullup_en == BITS_OFF && high_pullup_en == BITS_OFF)
    else $error("pins driven or pulled during hardware standby");

  chk_m2_addr_sel: assert property (
    is_m2 && awake |=> low_pin_oe == $past(low_ddr) && high_pin_oe == $past(high_ddr) &&
      low_pin_out == $past(ext_addr[7:0]) && high_pin_out == $past(ext_addr[15:8]))
    else $error("mode 2 pin does not follow direction and address");

  chk_hw_clear: assert property (
    st_reg.hw && !is_m1 |=> low_ddr == DDR_RST && high_ddr == DDR_RST &&
      low_dr == DR_RST && high_dr == DR_RST && low_pcr == PCR_RST && high_pcr == PCR_RST)
    else $error("hardware standby did not clear the port registers");

  chk_m3_data_drive: assert property (
    is_m3 && awake |=> low_pin_out == $past(low_dr) && high_pin_out == $past(high_dr) &&
      low_pin_oe == $past(low_ddr) && high_pin_oe == $past(high_ddr))
    else $error("mode 3 pin does not drive the data latch");

  chk_ddr_read_ones: assert property (
    s_access(ADDR_LOW_DDR, 1'b0) ##1 pready |-> prdata == {24'h00_0000, DDR_READ_VAL})
    else $error("direction register did not read as all ones");

  chk_dr_read_latch: assert property (
    s_access(ADDR_LOW_DR, 1'b0) ##0 (low_ddr == DDR_ALL_OUT || is_m1) ##1 pready |->
      prdata[PORT_W-1:0] == $past(low_dr))
    else $error("data read of an output bit did not return the latch");

  chk_latch_write: assert property (
    psel && penable && pready && !pslverr && pwrite && pstrb[0] && paddr == ADDR_HIGH_DR &&
      awake ##1 awake |-> high_dr == $past(pwdata[PORT_W-1:0]))
    else $error("data latch did not take the written byte");

  chk_pullup_gate: assert property (
    !is_m1 && awake |=> low_pullup_en == $past(low_pcr & ~low_ddr) &&
      high_pullup_en == $past(high_pcr & ~high_ddr))
    else $error("pull-up does not follow control and direction");

  chk_m1_pullup_off: assert property (
    is_m1 |=> low_pullup_en == BITS_OFF && high_pullup_en == BITS_OFF)
    else $error("pull-up enabled in mode 1");

  chk_apb_answer: assert property (
    s_access(ADDR_LOW_PCR, 1'b1) |=> pready && !pslverr ##1 !pready)
    else $error("register access not answered in one wait state");

  chk_unmapped_err: assert property (
    psel && penable && !pready && !mapped |=> pready && pslverr && prdata == RDATA_RST)
    else $error("unmapped access not answered with an error");

  // one write that lands on register a while the port is awake
  sequence s_write_done(logic [ADDR_W-1:0] a);
    wr_fire && paddr == a && awake;
  endsequence

  // first awake cycle after reset or hardware standby, mode 1 on neither side
  sequence s_wake;
    $fell(st_reg.hw) && !is_m1 && !$past(is_m1);
  endsequence

  chk_wake_all_inputs: assert property (
    s_wake |-> low_ddr == DDR_RST && high_ddr == DDR_RST ##1
      low_pin_oe == BITS_OFF && high_pin_oe == BITS_OFF)
    else $error("pins not all inputs after leaving reset or standby");

  // there is no software standby pin: state that is kept whenever no write lands
  // is exactly what carries the ports through a sleep
  chk_sleep_keeps_regs: assert property (
    awake && !wr_fire |=> $stable(low_dr) && $stable(high_dr) &&
      $stable(low_pcr) && $stable(high_pcr))
    else $error("latch or pull-up control changed without a write");

  chk_sleep_keeps_dir: assert property (
    awake && !wr_fire && !is_m1 |=> $stable(low_ddr) && $stable(high_ddr))
    else $error("direction changed without a write");

  chk_pcr_own_bits: assert property (
    s_write_done(ADDR_LOW_PCR) |=> low_pcr == $past(pwdata[PORT_W-1:0]) &&
      $stable(high_pcr))
    else $error("pull-up control write did not land on its own port alone");

  chk_ddr_write: assert property (
    s_write_done(ADDR_HIGH_DDR) ##0 !is_m1 |=> high_ddr == $past(pwdata[PORT_W-1:0]))
    else $error("direction write did not land outside mode 1");

  // a direction write in mode 1 would turn an address pin into an input
  chk_m1_dir_locked: assert property (
    s_write_done(ADDR_LOW_DDR) ##0 is_m1 |=> low_ddr == DDR_ALL_OUT)
    else $error("direction write took effect in mode 1");

  chk_m1_hw_dir: assert property (
    st_reg.hw && is_m1 |=> low_ddr == DDR_ALL_OUT && high_ddr == DDR_ALL_OUT)
    else $error("hardware standby in mode 1 did not reload all-ones direction");

  chk_high_ddr_read: assert property (
    s_access(ADDR_HIGH_DDR, 1'b0) ##1 pready |-> prdata == {24'h00_0000, DDR_READ_VAL})
    else $error("high direction register did not read as all ones");

  // bus side: one answer per access, read data parked in between
  chk_read_answer: assert property (
    s_access(ADDR_HIGH_DR, 1'b0) |=> pready && !pslverr ##1 !pready)
    else $error("data read not answered in one wait state");

  chk_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held for more than one cycle");

  chk_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("error flagged without ready");

  chk_rdata_hold: assert property (
    !(psel && penable && !pready) |=> $stable(prdata))
    else $error("read data changed outside an answer");

  chk_rdata_upper: assert property (
    pready |-> prdata[DATA_W-1:PORT_W] == 24'h00_0000)
    else $error("upper read data bits not zero");

  // lane 0 carries the byte, so a write without its strobe must leave the latches
  chk_strobe_gate: assert property (
    psel && penable && pready && pwrite && !pstrb[0] && awake |=>
      $stable(low_dr) && $stable(high_dr))
    else $error("write without lane strobe changed a data latch");

endmodule : agpp_top

// file: verification/agpp_pins_model.sv
`timescale 1ns/1ps
module agpp_pins_model (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] board_val,
  input wire logic [7:0] board_drv,
  output logic [7:0] pin_in
);
  logic [7:0] float_pat = 8'h55;
  // an undriven pin without pull-up has no stable level, so no stale value can pass for a read
  always @(posedge clk) begin
    float_pat <= ~float_pat;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (board_drv[i]) pin_in[i] = board_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_pat[i];
    end
  end
endmodule : agpp_pins_model

// file: verification/test_address_gpio_port_pair.sv
`timescale 1ns/1ps
module test_address_gpio_port_pair;
  import agpp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hw_standby_n = 1;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, err;
  logic [1:0] mode_pins = 2'b11;
  logic [15:0] ext_addr = 16'h0000;
  logic [7:0] l_in, l_out, l_oe, l_pu, h_in, h_out, h_oe, h_pu;
  logic [7:0] lb_val = 8'h96, hb_val = 8'h69, lb_drv = 8'hff, hb_drv = 8'hff;
  int fail_count = 0, n_tests = 0, cyc = 0;
  always #2 pclk = ~pclk;
  agpp_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_pins(mode_pins), .hw_standby_n(hw_standby_n),
    .ext_addr(ext_addr), .low_pin_in(l_in), .low_pin_out(l_out), .low_pin_oe(l_oe),
    .low_pullup_en(l_pu), .high_pin_in(h_in), .high_pin_out(h_out), .high_pin_oe(h_oe),
    .high_pullup_en(h_pu));
  agpp_pins_model low_board (.clk(pclk), .pin_out(l_out), .pin_oe(l_oe), .pullup_en(l_pu),
    .board_val(lb_val), .board_drv(lb_drv), .pin_in(l_in));
  agpp_pins_model high_board (.clk(pclk), .pin_out(h_out), .pin_oe(h_oe), .pullup_en(h_pu),
    .board_val(hb_val), .board_drv(hb_drv), .pin_in(h_in));
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // no answer time is assumed: only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [17:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d}, 4'hf);
  endtask : wr
  task rd_chk(input logic [17:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000, 4'hf);
    chk(rd[7:0], e);
    chk(rd[31:24] | rd[23:16] | rd[15:8] | {7'h00, err}, 8'h00);
  endtask : rd_chk
  task settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle
  task reset(input logic [1:0] m);
    @(posedge pclk);
    presetn <= 1'b0;
    mode_pins <= m;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    #1;
  endtask : reset
  task hw_stby;
    @(posedge pclk);
    hw_standby_n <= 1'b0;
    repeat (8) @(posedge pclk);
    #1;
  endtask : hw_stby
  initial begin
    reset(2'b11);
    chk(l_oe, 8'h00);
    chk(h_pu, 8'h00);
    rd_chk(ADDR_LOW_PCR, 8'h00);
    rd_chk(ADDR_HIGH_PCR, 8'h00);
    rd_chk(ADDR_LOW_DDR, 8'hff);
    rd_chk(ADDR_LOW_DR, 8'h96);
    wr(ADDR_LOW_PCR, 8'h0f);
    wr(ADDR_HIGH_PCR, 8'hf0);
    wr(ADDR_LOW_DDR, 8'h33);
    wr(ADDR_LOW_DR, 8'ha5);
    wr(ADDR_HIGH_DDR, 8'hc0);
    wr(ADDR_HIGH_DR, 8'hff);
    settle();
    chk(l_oe, 8'h33);
    chk(l_out & 8'h33, 8'h21);
    chk(l_pu, 8'h0c);
    chk(h_pu, 8'h30);
    rd_chk(ADDR_LOW_DR, 8'ha5);
    rd_chk(ADDR_HIGH_DR, 8'he9);
    rd_chk(ADDR_HIGH_DDR, 8'hff);
    rd_chk(ADDR_LOW_PCR, 8'h0f);
    // a write whose lane strobe is off leaves the latch alone
    apb(1'b1, ADDR_LOW_DR, 32'h0000_0000, 4'h0);
    rd_chk(ADDR_LOW_DR, 8'ha5);
    apb(1'b1, 18'h0_0100, 32'h0000_00ff, 4'hf);
    chk({7'h00, err}, 8'h01);
    apb(1'b0, 18'h0_0100, 32'h0000_0000, 4'hf);
    chk({7'h00, err} | rd[7:0], 8'h01);
    // board lets go of all pins but the unpulled inputs 7:6: the pulled-up inputs must now read high
    lb_drv <= 8'hc0;
    settle();
    rd_chk(ADDR_LOW_DR, 8'had);
    lb_drv <= 8'hff;
    hw_stby();
    chk(l_oe, 8'h00);
    chk(l_pu | h_pu, 8'h00);
    @(posedge pclk);
    hw_standby_n <= 1'b1;
    repeat (8) @(posedge pclk);
    rd_chk(ADDR_HIGH_PCR, 8'h00);
    wr(ADDR_LOW_DDR, 8'hff);
    rd_chk(ADDR_LOW_DR, 8'h00);
    settle();
    chk(l_out, 8'h00);
    @(posedge pclk);
    ext_addr <= 16'h5a3c;
    reset(2'b10);
    chk(l_oe | h_oe, 8'h00);
    wr(ADDR_LOW_DDR, 8'h0f);
    wr(ADDR_LOW_DR, 8'hff);
    wr(ADDR_HIGH_DDR, 8'hff);
    wr(ADDR_LOW_PCR, 8'hff);
    settle();
    chk(l_oe, 8'h0f);
    chk(l_out & 8'h0f, 8'h0c);
    chk(h_out, 8'h5a);
    chk(h_oe, 8'hff);
    chk(l_pu, 8'hf0);
    rd_chk(ADDR_LOW_DDR, 8'hff);
    ext_addr <= 16'hc3a5;
    settle();
    chk(h_out, 8'hc3);
    chk(l_out & 8'h0f, 8'h05);
    reset(2'b01);
    chk(l_oe & h_oe, 8'hff);
    chk(l_out, 8'ha5);
    chk(h_out, 8'hc3);
    wr(ADDR_LOW_DDR, 8'h00);
    wr(ADDR_LOW_PCR, 8'hff);
    wr(ADDR_HIGH_PCR, 8'hff);
    settle();
    chk(l_oe, 8'hff);
    rd_chk(ADDR_LOW_DDR, 8'hff);
    chk(l_pu | h_pu, 8'h00);
    hw_stby();
    chk(l_oe | h_oe, 8'h00);
    end_sim();
  end
endmodule : test_address_gpio_port_pair
